// [rtl/botpm_pkg.sv]
// constants and types for the option, timeout and power registers
package botpm_pkg;

    // register byte addresses
    localparam logic [7:0] OFF_OPTION = 8'h74;
    localparam logic [7:0] OFF_TIMEOUT = 8'h80;
    localparam logic [7:0] OFF_PMCAP = 8'hDC;
    localparam logic [7:0] OFF_PMCSR = 8'hE0;

    // option field sits in bits 11:7 of its word
    localparam int OPT_LSB = 7;
    localparam int OPT_MSB = 11;
    localparam int OPT_PRI_WI = 0;
    localparam int OPT_SEC_WI = 1;
    localparam int OPT_LONG_LOCK = 2;
    localparam int OPT_SEC_HOLD = 3;
    localparam int OPT_PRI_HOLD = 4;
    localparam logic [4:0] OPT_RESET = 5'h18;

    // master timeout word
    localparam int TMO_PRI_LSB = 0;
    localparam int TMO_SEC_LSB = 16;
    localparam logic [15:0] TMO_RESET = 16'h8000;

    // capability word fields
    localparam logic [7:0] CAP_ID_PM = 8'h01;
    localparam logic [7:0] CAP_NEXT_END = 8'h00;
    localparam logic [2:0] CAP_PM_REV = 3'h2;
    localparam int CAP_NEXT_LSB = 8;
    localparam int CAP_REV_LSB = 16;
    localparam int CAP_D1_BIT = 25;
    localparam int CAP_D2_BIT = 26;

    // power state field and encodings
    localparam int PS_LSB = 0;
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_DEEPEST = 2'h3;
    localparam logic [3:0] PS_IMPL_MASK = 4'hF;

    // bus command codes seen by the forwarding path
    localparam logic [3:0] CMD_PLAIN_MEM_WRITE = 4'h7;
    localparam logic [3:0] CMD_WRITE_INVALIDATE = 4'hF;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } botpm_wr_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } botpm_rd_t;

    typedef struct packed {
        botpm_wr_t wst;
        botpm_rd_t rdst;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [4:0] opt;
        logic [15:0] tmo_pri;
        logic [15:0] tmo_sec;
        logic [1:0] ps;
        logic soft_rst;
        logic [15:0] p_cnt;
        logic [15:0] s_cnt;
        logic p_tmo;
        logic s_tmo;
        logic p_req;
        logic s_req;
        logic [3:0] p2s_cmd;
        logic [3:0] s2p_cmd;
    } botpm_state_t;

endpackage

// [rtl/botpm_regs.sv]
// option, master timeout and power management registers of the bridge
//
// What this block does
// - bit7 clear converts primary write-invalidate to memory write
// - bit8 clear converts secondary write-invalidate to memory write
// - bit9 enables long requests during locked cycles
// - bit10 holds secondary request until queue empty
// - bit11 holds primary request until queue empty
// - primary timeout count, low half, resets 8000h
// - secondary timeout count, high half, resets 8000h
// - capability identifier reads power management code
// - next capability pointer reads zero
// - revision field reads 010 pattern
// - wake, aux, init, reserved bits read zero
// - D1 and D2 support bits read one
// - two-bit power state field, resets to D0
// - unimplemented state write completes, data discarded
// - D0 written from deepest state pulses internal reset
// - power register reserved and wake bits read zero
`timescale 1ns/1ns
module botpm_regs
    import botpm_pkg::*;
(
    input wire logic mclk, // 50 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response code
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response code
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [3:0] pri_cmd_in, // command taken on primary
    input wire logic [3:0] sec_cmd_in, // command taken on secondary
    output logic [3:0] pri_fwd_cmd, // primary command, as forwarded
    output logic [3:0] sec_fwd_cmd, // secondary command, as forwarded
    input wire logic pri_pending, // primary master queue not empty
    input wire logic pri_frame, // primary master drives frame
    input wire logic pri_target_term, // primary target terminated
    input wire logic pri_lock, // primary master in locked cycle
    output logic pri_req, // primary master bus request
    input wire logic sec_pending, // secondary master queue not empty
    input wire logic sec_frame, // secondary master drives frame
    input wire logic sec_target_term, // secondary target terminated
    input wire logic sec_lock, // secondary master in locked cycle
    output logic sec_req, // secondary master bus request
    input wire logic pri_wait, // primary master awaiting completion
    input wire logic sec_wait, // secondary master awaiting completion
    output logic pri_timeout, // primary master timeout pulse
    output logic sec_timeout, // secondary master timeout pulse
    output logic [1:0] power_state, // current power state
    output logic internal_reset // one-cycle internal reset pulse
);

    localparam botpm_state_t ST_RESET = '{
        wst: WR_IDLE,
        rdst: RD_IDLE,
        aw_held: 1'b0,
        awaddr: 8'h00,
        w_held: 1'b0,
        wdata: 32'h0000_0000,
        wstrb: 4'h0,
        awready: 1'b1,
        wready: 1'b1,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rdata: 32'h0000_0000,
        rresp: RESP_OKAY,
        opt: OPT_RESET,
        tmo_pri: TMO_RESET,
        tmo_sec: TMO_RESET,
        ps: PS_D0,
        soft_rst: 1'b0,
        p_cnt: 16'h0000,
        s_cnt: 16'h0000,
        p_tmo: 1'b0,
        s_tmo: 1'b0,
        p_req: 1'b0,
        s_req: 1'b0,
        p2s_cmd: 4'h0,
        s2p_cmd: 4'h0
    };

    botpm_state_t s_r;
    botpm_state_t s_nxt;

    // true for the four words this block decodes
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == OFF_OPTION) || (a == OFF_TIMEOUT) ||
                    (a == OFF_PMCAP) || (a == OFF_PMCSR);
    endfunction

    // read view of a word; fixed fields are constants
    function automatic logic [31:0] reg_read(
        input logic [7:0] a,
        input botpm_state_t st
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            OFF_OPTION: begin
                v[OPT_MSB:OPT_LSB] = st.opt;
            end
            OFF_TIMEOUT: begin
                v[TMO_PRI_LSB +: 16] = st.tmo_pri;
                v[TMO_SEC_LSB +: 16] = st.tmo_sec;
            end
            OFF_PMCAP: begin
                v[7:0] = CAP_ID_PM;
                v[CAP_NEXT_LSB +: 8] = CAP_NEXT_END;
                v[CAP_REV_LSB +: 3] = CAP_PM_REV;
                v[CAP_D1_BIT] = 1'b1;
                v[CAP_D2_BIT] = 1'b1;
                // all other capability bits stay zero
            end
            OFF_PMCSR: begin
                v[PS_LSB +: 2] = st.ps;
                // bits 31:2 stay zero
            end
            default: begin
                v = 32'h0000_0000;
            end
        endcase
        reg_read = v;
    endfunction

    // byte-lane merge of new write data over the old word
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                v[8*i +: 8] = wd[8*i +: 8];
            end
        end
        merge = v;
    endfunction

    // write-invalidate passes unchanged only when keep is set
    function automatic logic [3:0] fwd_cmd(
        input logic [3:0] cmd,
        input logic keep
    );
        if (!keep && cmd == CMD_WRITE_INVALIDATE) begin
            fwd_cmd = CMD_PLAIN_MEM_WRITE;
        end else begin
            fwd_cmd = cmd;
        end
    endfunction

    // bus request of one internal master
    // lock with long requests outranks a target termination
    function automatic logic req_next(
        input logic pending,
        input logic frame,
        input logic term,
        input logic lock,
        input logic hold,
        input logic long_lock
    );
        if (!pending) begin
            req_next = 1'b0;
        end else if (lock && long_lock) begin
            req_next = 1'b1; // long request over the locked cycle
        end else if (term) begin
            req_next = 1'b0; // target termination ends the request
        end else if (hold) begin
            req_next = 1'b1; // kept while work remains queued
        end else begin
            req_next = !frame; // released once frame is driven
        end
    endfunction

    // master timeout counter step: counts while waiting
    function automatic logic [15:0] tmo_count(
        input logic [15:0] cnt,
        input logic waiting,
        input logic [15:0] limit
    );
        logic [15:0] inc;
        // a limit of zero wraps and fires after 65536 cycles
        inc = cnt + 16'h0001;
        if (!waiting || inc == limit) begin
            tmo_count = 16'h0000;
        end else begin
            tmo_count = inc;
        end
    endfunction

    // all next-state logic
    always_comb begin
        logic [31:0] mw;
        logic [1:0] new_ps;
        mw = 32'h0000_0000;
        new_ps = PS_D0;
        // every field but soft_rst holds unless a branch below moves it
        s_nxt = s_r;
        s_nxt.soft_rst = 1'b0;

        // internal reset reloads the block's own settings
        if (s_r.soft_rst) begin
            s_nxt.opt = OPT_RESET;
            s_nxt.tmo_pri = TMO_RESET;
            s_nxt.tmo_sec = TMO_RESET;
            s_nxt.p_cnt = 16'h0000;
            s_nxt.s_cnt = 16'h0000;
        end

        // capture write address and data in either order
        if (s_r.awready && s_axi_awvalid) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_r.wready && s_axi_wvalid) begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end

        // write sequence
        case (s_r.wst)
            WR_IDLE: begin
                if (s_nxt.aw_held && s_nxt.w_held) begin
                    // merging over the read view keeps fixed bits fixed
                    mw = merge(reg_read(s_nxt.awaddr, s_r),
                               s_nxt.wdata, s_nxt.wstrb);
                    s_nxt.bresp = RESP_OKAY;
                    case (s_nxt.awaddr)
                        OFF_OPTION: begin
                            s_nxt.opt = mw[OPT_MSB:OPT_LSB];
                        end
                        OFF_TIMEOUT: begin
                            s_nxt.tmo_pri = mw[TMO_PRI_LSB +: 16];
                            s_nxt.tmo_sec = mw[TMO_SEC_LSB +: 16];
                        end
                        OFF_PMCAP: begin
                            s_nxt.bresp = RESP_OKAY;
                        end
                        OFF_PMCSR: begin
                            new_ps = mw[PS_LSB +: 2];
                            if (PS_IMPL_MASK[new_ps]) begin
                                if (s_r.ps == PS_DEEPEST &&
                                    new_ps == PS_D0) begin
                                    s_nxt.soft_rst = 1'b1;
                                end
                                s_nxt.ps = new_ps;
                            end
                        end
                        default: begin
                            s_nxt.bresp = RESP_DECERR;
                        end
                    endcase
                    s_nxt.aw_held = 1'b0;
                    s_nxt.w_held = 1'b0;
                    s_nxt.bvalid = 1'b1;
                    s_nxt.wst = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    s_nxt.bvalid = 1'b0;
                    s_nxt.wst = WR_IDLE;
                end
            end
            default: begin
                s_nxt.bvalid = 1'b0;
                s_nxt.wst = WR_IDLE;
            end
        endcase
        // ready stays low until the write response is taken
        s_nxt.awready = (s_nxt.wst == WR_IDLE) && !s_nxt.aw_held;
        s_nxt.wready = (s_nxt.wst == WR_IDLE) && !s_nxt.w_held;

        // read sequence
        case (s_r.rdst)
            RD_IDLE: begin
                if (s_r.arready && s_axi_arvalid) begin
                    s_nxt.rdata = reg_read(s_axi_araddr, s_r);
                    s_nxt.rresp = is_mapped(s_axi_araddr) ?
                                  RESP_OKAY : RESP_DECERR;
                    s_nxt.rvalid = 1'b1;
                    s_nxt.rdst = RD_RESP;
                end
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    s_nxt.rvalid = 1'b0;
                    s_nxt.rdst = RD_IDLE;
                end
            end
            default: begin
                s_nxt.rvalid = 1'b0;
                s_nxt.rdst = RD_IDLE;
            end
        endcase
        // one read at a time; the next address waits for rready
        s_nxt.arready = (s_nxt.rdst == RD_IDLE);

        // command forwarding
        // one cycle of latency keeps the forwarded command registered
        s_nxt.p2s_cmd = fwd_cmd(pri_cmd_in,
                                s_r.opt[OPT_PRI_WI]);
        s_nxt.s2p_cmd = fwd_cmd(sec_cmd_in,
                                s_r.opt[OPT_SEC_WI]);

        // bus requests of the two internal masters
        s_nxt.p_req = req_next(pri_pending, pri_frame,
                               pri_target_term, pri_lock,
                               s_r.opt[OPT_PRI_HOLD],
                               s_r.opt[OPT_LONG_LOCK]);
        s_nxt.s_req = req_next(sec_pending, sec_frame,
                               sec_target_term, sec_lock,
                               s_r.opt[OPT_SEC_HOLD],
                               s_r.opt[OPT_LONG_LOCK]);

        // master timeout counters
        // a pending internal reset restarts both counters
        if (!s_r.soft_rst) begin
            s_nxt.p_cnt = tmo_count(s_r.p_cnt, pri_wait, s_r.tmo_pri);
            s_nxt.s_cnt = tmo_count(s_r.s_cnt, sec_wait, s_r.tmo_sec);
        end
        // pulse on the edge at which the count reaches its limit
        s_nxt.p_tmo = pri_wait && !s_r.soft_rst &&
                      (s_r.p_cnt + 16'h0001 == s_r.tmo_pri);
        s_nxt.s_tmo = sec_wait && !s_r.soft_rst &&
                      (s_r.s_cnt + 16'h0001 == s_r.tmo_sec);
    end

    // state register
    // async reset loads the default of every field
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs come straight from the state register
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign pri_fwd_cmd = s_r.p2s_cmd;
    assign sec_fwd_cmd = s_r.s2p_cmd;
    assign pri_req = s_r.p_req;
    assign sec_req = s_r.s_req;
    assign pri_timeout = s_r.p_tmo;
    assign sec_timeout = s_r.s_tmo;
    assign power_state = s_r.ps;
    assign internal_reset = s_r.soft_rst; // secondary bus reset untouched

endmodule

// [bench/botpm_far.sv]
// arbiter model for one bridge port: grants and drives frame
`timescale 1ns/1ns
module botpm_far (
    input wire logic mclk, // clock
    input wire logic req, // bus request from the bridge
    input wire logic pend_i, // queued work, set by the bench
    output logic pending = 1'h0, // queue not empty
    output logic frame = 1'h0 // frame, one cycle after the grant
);
    // grant as soon as a request is seen; frame ends with the queue
    always_ff @(posedge mclk) begin
        pending <= pend_i;
        frame <= req & pend_i;
    end
endmodule

// [bench/botpm_monitor.sv]
// assertion checker for the option, timeout and power registers
`timescale 1ns/1ns
module botpm_monitor (
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    input wire logic s_axi_arready, // read address ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic s_axi_rvalid, // read data valid
    input wire logic s_axi_bvalid, // write response valid
    input wire logic [3:0] pri_cmd_in, // primary command
    input wire logic [3:0] pri_fwd_cmd, // primary forwarded
    input wire logic [3:0] sec_cmd_in, // secondary command
    input wire logic [3:0] sec_fwd_cmd, // secondary forwarded
    input wire logic pri_pending, // primary queue
    input wire logic pri_req, // primary request
    input wire logic sec_pending, // secondary queue
    input wire logic sec_req, // secondary request
    input wire logic pri_wait, // primary waiting
    input wire logic pri_timeout, // primary timeout
    input wire logic [1:0] power_state, // power state
    input wire logic internal_reset // internal reset pulse
);
    logic [7:0] rd_addr_r; // address of the read in flight
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // remember which register is being read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            rd_addr_r <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready)
            rd_addr_r <= s_axi_araddr;
    end
    pri_pass_a: assert property (
        !$past(rst) && $past(pri_cmd_in) != 4'hF
        |-> pri_fwd_cmd == $past(pri_cmd_in))
        else $error("primary command altered");
    sec_pass_a: assert property (
        !$past(rst) && $past(sec_cmd_in) != 4'hF
        |-> sec_fwd_cmd == $past(sec_cmd_in))
        else $error("secondary command altered");
    pri_req_idle_a: assert property (
        !pri_pending |=> !pri_req)
        else $error("primary request without queued work");
    sec_req_idle_a: assert property (
        !sec_pending |=> !sec_req)
        else $error("secondary request without queued work");
    state_write_a: assert property (
        $changed(power_state) |-> s_axi_bvalid)
        else $error("power state moved without a write");
    wake_reset_a: assert property (
        internal_reset |-> $past(power_state) == 2'h3 && power_state == 2'h0
        ##1 !internal_reset) else $error("internal reset out of place");
    pri_timeout_a: assert property (
        pri_timeout |-> $past(pri_wait))
        else $error("primary timeout while not waiting");
    cap_word_a: assert property (
        s_axi_rvalid && rd_addr_r == 8'hDC |-> s_axi_rdata == 32'h0602_0001)
        else $error("capability word wrong");
endmodule
bind botpm_regs botpm_monitor mon (
    .mclk(mclk), .rst(rst), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_bvalid(s_axi_bvalid), .pri_cmd_in(pri_cmd_in),
    .pri_fwd_cmd(pri_fwd_cmd), .sec_cmd_in(sec_cmd_in),
    .sec_fwd_cmd(sec_fwd_cmd), .pri_pending(pri_pending),
    .pri_req(pri_req), .sec_pending(sec_pending), .sec_req(sec_req),
    .pri_wait(pri_wait), .pri_timeout(pri_timeout),
    .power_state(power_state), .internal_reset(internal_reset)
);

// [bench/tb_top.sv]
// self-checking bench for the option, timeout and power registers
`timescale 1ns/1ns
module tb_top;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] ws = 4'h0, pcmd = 4'h0, scmd = 4'h0;
    logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic pp = 1'h0, sp = 1'h0, term = 1'h0, lock = 1'h0, wt = 1'h0;
    logic awr, wrd, bv, arr, rv, preq, sreq, pfr, sfr, ppd, spd;
    logic ptmo, stmo, irst;
    logic [1:0] br, rr, ps;
    logic [31:0] rd;
    logic [3:0] pfw, sfw;
    int error_cnt = 0;
    int checks = 0;
    int ir_cnt = 0;
    always #10 mclk = ~mclk;
    botpm_regs DUT (
        .mclk(mclk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .pri_cmd_in(pcmd), .sec_cmd_in(scmd), .pri_fwd_cmd(pfw),
        .sec_fwd_cmd(sfw), .pri_pending(ppd), .pri_frame(pfr),
        .pri_target_term(term), .pri_lock(lock), .pri_req(preq),
        .sec_pending(spd), .sec_frame(sfr), .sec_target_term(term),
        .sec_lock(lock), .sec_req(sreq), .pri_wait(wt), .sec_wait(wt),
        .pri_timeout(ptmo), .sec_timeout(stmo), .power_state(ps),
        .internal_reset(irst)
    );
    botpm_far far_p (.mclk(mclk), .req(preq), .pend_i(pp),
        .pending(ppd), .frame(pfr));
    botpm_far far_s (.mclk(mclk), .req(sreq), .pend_i(sp),
        .pending(spd), .frame(sfr));
    // count internal reset pulses
    always @(posedge mclk) begin
        if (irst === 1'h1)
            ir_cnt++;
    end
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one bus access; d is write data or the expected read data
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
                       logic [3:0] s, logic [1:0] er);
        logic [31:0] got;
        logic [1:0] gr;
        logic done;
        got = 32'hX;
        gr = 2'hX;
        done = 1'h0;
        awa <= a;
        ara <= a;
        wd <= d;
        ws <= s;
        awv <= w;
        wv <= w;
        bry <= w;
        arv <= !w;
        rry <= !w;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge mclk);
            if (awr && awv)
                awv <= 1'h0;
            if (wrd && wv)
                wv <= 1'h0;
            if (arr && arv)
                arv <= 1'h0;
            if ((bv && bry) || (rv && rry)) begin
                got = bry ? d : rd;
                gr = bry ? br : rr;
                bry <= 1'h0;
                rry <= 1'h0;
                done = 1'h1;
            end
        end
        @(posedge mclk);
        check($sformatf("data at %h", a), got, d);
        check($sformatf("resp at %h", a), gr, er);
    endtask
    // cycles out of six with each request low
    task automatic lows(output int p, output int s);
        p = 0;
        s = 0;
        repeat (6) begin
            @(posedge mclk);
            p += (preq !== 1'h1);
            s += (sreq !== 1'h1);
        end
    endtask
    initial begin
        int m, p, s, tp, ts;
        logic [3:0] c, ep, es;
        repeat (16) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        bus(0, 8'h74, 32'h0C00, 4'hF, 2'h0);
        bus(0, 8'h80, 32'h8000_8000, 4'hF, 2'h0);
        bus(0, 8'hDC, 32'h0602_0001, 4'hF, 2'h0);
        bus(0, 8'hE0, 32'h0, 4'hF, 2'h0);
        bus(0, 8'h40, 32'h0, 4'hF, 2'h3);
        bus(1, 8'h40, 32'hFFFF_FFFF, 4'hF, 2'h3);
        bus(1, 8'hDC, 32'hFFFF_FFFF, 4'hF, 2'h0);
        bus(0, 8'hDC, 32'h0602_0001, 4'hF, 2'h0);
        bus(1, 8'h74, 32'hFFFF_FFFF, 4'hF, 2'h0);
        bus(0, 8'h74, 32'h0F80, 4'hF, 2'h0);
        bus(1, 8'hE0, 32'hFFFF_FFFE, 4'hF, 2'h0);
        bus(0, 8'hE0, 32'h2, 4'hF, 2'h0);
        $display("test registers done");
        for (m = 0; m < 4; m++) begin
            bus(1, 8'h74, 32'(m) << 7, 4'h3, 2'h0);
            for (int k = 0; k < 3; k++) begin
                c = (k == 0) ? 4'hF : (k == 1) ? 4'h7 : 4'h2;
                pcmd <= c;
                scmd <= c;
                repeat (2) @(posedge mclk);
                ep = (c == 4'hF && !m[0]) ? 4'h7 : c;
                es = (c == 4'hF && !m[1]) ? 4'h7 : c;
                check("pri_fwd", pfw, ep);
                check("sec_fwd", sfw, es);
            end
        end
        pcmd <= 4'h0;
        scmd <= 4'h0;
        $display("test forwarding done");
        for (m = 0; m < 2; m++) begin
            bus(1, 8'h74, m ? 32'h400 : 32'h800, 4'hF, 2'h0);
            pp <= 1'h1;
            sp <= 1'h1;
            repeat (4) @(posedge mclk);
            lows(p, s);
            check("pri_drops", p != 0, m == 1);
            check("sec_drops", s != 0, m == 0);
        end
        bus(1, 8'h74, 32'hE00, 4'hF, 2'h0);
        term <= 1'h1;
        lock <= 1'h1;
        repeat (2) @(posedge mclk);
        lows(p, s);
        check("lock_hold", p + s, 0);
        bus(1, 8'h74, 32'hC00, 4'hF, 2'h0);
        lows(p, s);
        check("term_drop", p + s, 12);
        term <= 1'h0;
        lock <= 1'h0;
        pp <= 1'h0;
        sp <= 1'h0;
        $display("test requests done");
        bus(1, 8'h80, 32'h0006_0004, 4'hF, 2'h0);
        wt <= 1'h1;
        tp = 0;
        ts = 0;
        for (m = 0; m < 12; m++) begin
            @(posedge mclk);
            if (ptmo === 1'h1 && tp == 0)
                tp = m;
            if (stmo === 1'h1 && ts == 0)
                ts = m;
        end
        wt <= 1'h0;
        check("pri_tmo", tp, 4);
        check("sec_tmo", ts, 6);
        $display("test timeouts done");
        bus(1, 8'hE0, 32'h1, 4'h2, 2'h0);
        check("state_kept", ps, 2'h2);
        bus(1, 8'hE0, 32'h3, 4'hF, 2'h0);
        bus(1, 8'h74, 32'h0, 4'hF, 2'h0);
        bus(1, 8'hE0, 32'h0, 4'hF, 2'h0);
        check("wake_pulses", ir_cnt, 1);
        bus(0, 8'h74, 32'h0C00, 4'hF, 2'h0);
        bus(0, 8'h80, 32'h8000_8000, 4'hF, 2'h0);
        bus(1, 8'hE0, 32'h1, 4'hF, 2'h0);
        bus(1, 8'hE0, 32'h0, 4'hF, 2'h0);
        check("d1_wake", ir_cnt, 1);
        check("state_d0", ps, 2'h0);
        $display("test power done");
        test_done();
    end
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        test_done();
    end
endmodule
